// ### rtl/lcd_pwr_pkg.sv
package lcd_pwr_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] power_save_control_addr = 8'h00;
  localparam logic [7:0] status_addr             = 8'h04;
  localparam logic [7:0] panel_config_addr       = 8'h08;
  localparam logic [7:0] gpio_out_addr           = 8'h0C;
  localparam logic [7:0] lut_base_addr           = 8'h40;
  localparam logic [7:0] frame_len_addr          = 8'h10;
  localparam logic [7:0] mem_window_addr         = 8'h80;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int         ps_bits_lsb      = 0;
  localparam logic [1:0] ps_normal        = 2'h3;
  localparam logic [1:0] ps_soft          = 2'h0;
  localparam logic [1:0] ps_reset_value   = 2'h0;
  localparam int         cfg_hwps_en_bit  = 0;
  localparam int         cfg_gpio_sel_bit = 1;
  localparam logic [1:0] cfg_reset_value  = 2'h0;
  localparam logic [3:0] gpio_reset_value = 4'h0;
  localparam logic [15:0] frame_len_reset = 16'h0100;

  // ----------------------------------------------------------------
  // Timing and table depths
  // ----------------------------------------------------------------
  localparam logic [7:0] seq_frames       = 8'd127;
  localparam int         lut_words        = 16;
  localparam int         mem_words        = 16;

  typedef enum logic [2:0] {
    st_off,
    st_power_up,
    st_on,
    st_power_down
  } seq_state_e;

  typedef enum logic [1:0] {
    mode_normal,
    mode_soft_save,
    mode_hard_save,
    mode_reserved
  } save_mode_e;

  typedef struct packed {
    logic [11:0] data;
    logic        shift_clock;
    logic        line;
    logic        frame;
    logic        enable;
    logic        power;
  } panel_s;

endpackage

// ### rtl/lcd_power_save_sequencer.sv
`timescale 1ns/1ps
`default_nettype none

// How it works
// - Hardware save pin wins; else bits 00 soft save, 11 normal, else reserved
// - Soft save powers panel down and halts refresh reads
// - Soft save still serves host register and memory accesses
// - Hardware save blocks all host access and buffer reads
// - Lookup table reachable only in normal operation
// - Hard save drives panel outputs low at once, soft save after power-down; power enable inactive in both
// - Upper data pins set as GPIO keep their level during save
// - After reset panel power inactive and outputs low until power-up
// - Writing 11 to save bits starts the panel power-up sequence
// - Power-up and soft save power-down delay is 127 frames; hard save powers down at once
// - Entering soft save powers down, leaving it for normal powers up
module lcd_power_save_sequencer
  import lcd_pwr_pkg::*;
#(
  parameter int lut_depth = lut_words,
  parameter int mem_depth = mem_words
)
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  input  wire logic        hw_power_save,
  output logic [11:0]      panel_data_bus,
  output logic             panel_shift_clock,
  output logic             line_pulse,
  output logic             frame_pulse,
  output logic             display_enable_out,
  output logic             panel_power_enable,
  output logic             refresh_active,
  output logic             save_mode_clock_ok
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [1:0]            ps_bits;
    logic [1:0]            cfg;
    logic [3:0]            gpio;
    logic [15:0]           frame_len;
    seq_state_e            seq;
    logic [7:0]            seq_cnt;
    logic [15:0]           pix_cnt;
    logic [7:0]            save_frames;
    logic                  dp_valid;
    logic                  dp_write;
    logic [7:0]            dp_addr;
    logic [31:0]           rdata;
    panel_s                pan;
    logic [lut_depth-1:0][31:0] color_lookup_table;
    logic [mem_depth-1:0][31:0] mem;
  } state_s;

  state_s state_reg;
  state_s state_next;
  save_mode_e mode;
  logic frame_tick;
  logic lut_hit;
  logic mem_hit;
  logic host_ok;

  function automatic logic in_range(input logic [7:0] a,
                                    input logic [7:0] base,
                                    input int         words);
    in_range = (a >= base) && (a < 8'(int'(base) + 4 * words));
  endfunction

  function automatic logic [3:0] word_index(input logic [7:0] a,
                                            input logic [7:0] base);
    logic [7:0] off;
    off = a - base;
    word_index = off[5:2];
  endfunction

  // ----------------------------------------------------------------
  // Mode decode
  // ----------------------------------------------------------------
  always_comb
  begin
    if (state_reg.cfg[cfg_hwps_en_bit] && hw_power_save)
      mode = mode_hard_save;
    else if (state_reg.ps_bits == ps_normal)
      mode = mode_normal;
    else if (state_reg.ps_bits == ps_soft)
      mode = mode_soft_save;
    else
      mode = mode_reserved;
  end

  assign host_ok   = (mode != mode_hard_save);
  assign frame_tick = (state_reg.pix_cnt == state_reg.frame_len);
  assign lut_hit   = in_range(state_reg.dp_addr, lut_base_addr, lut_depth);
  assign mem_hit   = in_range(state_reg.dp_addr, mem_window_addr, mem_depth);

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    logic run;
    run = 1'b0;
    state_next = state_reg;
    state_next.rdata = 32'h0000_0000;

    // Address phase capture
    state_next.dp_valid = hsel && hready && htrans[1] && host_ok;
    state_next.dp_write = hwrite;
    state_next.dp_addr  = haddr[7:0];

    // ------------------------------------------------------------
    // Host data phase
    // ------------------------------------------------------------
    if (state_reg.dp_valid)
    begin
      if (state_reg.dp_write)
      begin
        // registers and memory serve in soft save
        if (state_reg.dp_addr == power_save_control_addr)
          state_next.ps_bits = hwdata[ps_bits_lsb +: 2];
        else if (state_reg.dp_addr == panel_config_addr)
          state_next.cfg = hwdata[1:0];
        else if (state_reg.dp_addr == gpio_out_addr)
          state_next.gpio = hwdata[3:0];
        else if (state_reg.dp_addr == frame_len_addr)
          state_next.frame_len = hwdata[15:0];
        else if (lut_hit && mode == mode_normal)
          state_next.color_lookup_table[word_index(state_reg.dp_addr, lut_base_addr)]
            = hwdata;
        else if (mem_hit)
          state_next.mem[word_index(state_reg.dp_addr, mem_window_addr)]
            = hwdata;
      end
    end
    // ------------------------------------------------------------
    // Read data, registered to stand through the data phase
    // ------------------------------------------------------------
    if (state_next.dp_valid && !hwrite)
    begin
      if (haddr[7:0] == power_save_control_addr)
        state_next.rdata = {30'h0, state_reg.ps_bits};
      else if (haddr[7:0] == status_addr)
        state_next.rdata = {24'h0,
                            state_reg.save_frames == 8'd128,
                            3'(state_reg.seq),
                            mode,
                            2'h0};
      else if (haddr[7:0] == panel_config_addr)
        state_next.rdata = {30'h0, state_reg.cfg};
      else if (haddr[7:0] == gpio_out_addr)
        state_next.rdata = {28'h0, state_reg.gpio};
      else if (haddr[7:0] == frame_len_addr)
        state_next.rdata = {16'h0, state_reg.frame_len};
      else if (in_range(haddr[7:0], lut_base_addr, lut_depth))
      begin
        if (mode == mode_normal)
          state_next.rdata =
            state_reg.color_lookup_table[word_index(haddr[7:0], lut_base_addr)];
      end
      else if (in_range(haddr[7:0], mem_window_addr, mem_depth))
        state_next.rdata =
          state_reg.mem[word_index(haddr[7:0], mem_window_addr)];
    end

    // ------------------------------------------------------------
    // Frame timing; halted outside normal once the sequencer is in st_off
    // ------------------------------------------------------------
    // refresh stops in save modes once the sequencer reaches st_off
    if (mode == mode_normal || state_reg.seq != st_off)
      state_next.pix_cnt = frame_tick ? 16'h0000 : state_reg.pix_cnt + 16'h1;
    else
      state_next.pix_cnt = 16'h0000;

    // Clock cycles since entering a save mode, saturating at 128, for clock stop hint
    // save mode cycle count
    if (mode == mode_normal)
      state_next.save_frames = 8'h00;
    else if (state_reg.save_frames != 8'd128)
      state_next.save_frames = state_reg.save_frames + 8'h1;

    // ------------------------------------------------------------
    // Panel power sequencer
    // ------------------------------------------------------------
    // power-up on 11b
    case (state_reg.seq)
      st_off:
        if (mode == mode_normal)
        begin
          state_next.seq = st_power_up;
          state_next.seq_cnt = 8'h00;
        end
      st_power_up:
        if (mode != mode_normal)
          state_next.seq = st_off;
        else if (frame_tick)
        begin
          state_next.seq_cnt = state_reg.seq_cnt + 8'h1;
          if (state_reg.seq_cnt + 8'h1 == seq_frames)
            state_next.seq = st_on;
        end
      st_on:
        if (mode != mode_normal)
        begin
          state_next.seq = st_power_down;
          state_next.seq_cnt = 8'h00;
        end
      st_power_down:
        if (frame_tick || mode == mode_hard_save)
        begin
          state_next.seq_cnt = state_reg.seq_cnt + 8'h1;
          if (state_reg.seq_cnt + 8'h1 == seq_frames ||
              mode == mode_hard_save)
            state_next.seq = st_off;
        end
      default:
        state_next.seq = st_off;
    endcase

    // ------------------------------------------------------------
    // Panel drive; signals run from the start of power-up, power last
    // ------------------------------------------------------------
    // St_power_down counts too, so no gap opens as power-down begins
    run = (state_reg.seq == st_on || state_reg.seq == st_power_down ||
           (state_reg.seq == st_power_up && mode == mode_normal)) &&
          mode != mode_hard_save;
    state_next.pan = '0;
    if (run)
    begin
      state_next.pan.shift_clock = ~state_reg.pan.shift_clock;
      state_next.pan.frame  = (state_reg.pix_cnt == 16'h0000);
      state_next.pan.line   = (state_reg.pix_cnt[3:0] == 4'h0);
      state_next.pan.enable = 1'b1;
      state_next.pan.data[7:0] = state_reg.mem[state_reg.pix_cnt[3:0]][7:0];
      state_next.pan.data[11:8] =
        state_reg.mem[state_reg.pix_cnt[3:0]][11:8];
      state_next.pan.power = (state_reg.seq == st_on) &&
                             (mode == mode_normal);
    end
    if (state_reg.cfg[cfg_gpio_sel_bit])
      state_next.pan.data[11:8] = state_reg.gpio;
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      state_reg           <= '0;
      state_reg.ps_bits   <= ps_reset_value;
      state_reg.cfg       <= cfg_reset_value;
      state_reg.gpio      <= gpio_reset_value;
      state_reg.frame_len <= frame_len_reset;
      state_reg.seq       <= st_off;
    end
    else
      state_reg <= state_next;
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Zero wait states: the registered read path never needs a stall
  assign hreadyout          = 1'b1;
  assign hresp              = 1'b0;
  assign hrdata             = state_reg.rdata;
  assign panel_data_bus     = state_reg.pan.data;
  assign panel_shift_clock  = state_reg.pan.shift_clock;
  assign line_pulse         = state_reg.pan.line;
  assign frame_pulse        = state_reg.pan.frame;
  assign display_enable_out = state_reg.pan.enable;
  assign panel_power_enable = state_reg.pan.power;
  assign refresh_active     = (mode == mode_normal);
  assign save_mode_clock_ok = (state_reg.save_frames == 8'd128);

endmodule

`default_nettype wire

// ### bench/lcd_pwr_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module lcd_pwr_checker (
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic [31:0] hrdata,
  input wire logic [11:0] panel_data_bus,
  input wire logic        frame_pulse,
  input wire logic        panel_power_enable,
  input wire logic        refresh_active,
  input wire logic        save_mode_clock_ok
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic       rd_go;
  logic [7:0] run_reg;
  assign rd_go = hsel && hready && htrans[1] && !hwrite;
  // Saturates so long sequences cannot wrap back under the limit
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn) run_reg <= 8'h00;
    else if (!refresh_active) run_reg <= 8'h00;
    else if (run_reg != 8'hFF) run_reg <= run_reg + 8'h01;
  ready_always_a: assert property (hreadyout)
    else $error("hreadyout low");
  resp_okay_a: assert property (!hresp)
    else $error("hresp not okay");
  save_power_off_a: assert property (
    !refresh_active |=> !panel_power_enable)
    else $error("power enable high in save");
  reset_outs_low_a: assert property ($rose(hresetn) |->
    !panel_power_enable && panel_data_bus == 12'h000 && !frame_pulse)
    else $error("panel outputs active after reset");
  up_needs_normal_a: assert property ($rose(panel_power_enable) |->
    $past(refresh_active)) else $error("power up outside normal");
  up_delay_a: assert property ($rose(panel_power_enable) |->
    run_reg >= 8'd127) else $error("power up too early");
  lut_save_zero_a: assert property (rd_go && !refresh_active &&
    haddr[7:6] == 2'b01 |=> hrdata == 32'h0000_0000)
    else $error("lookup table readable in save");
  idle_rdata_a: assert property (!rd_go |=> hrdata == 32'h0000_0000)
    else $error("hrdata not zero outside read");
  clock_ok_save_a: assert property ($rose(save_mode_clock_ok) |->
    $past(refresh_active) == 1'b0) else $error("clock ok in normal");
  cover property ($rose(panel_power_enable));
  cover property ($rose(save_mode_clock_ok));
  cover property (rd_go && !refresh_active && haddr[7:6] == 2'b01);
endmodule
bind lcd_power_save_sequencer lcd_pwr_checker lcd_pwr_checker_inst (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hready(hready),
  .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
  .panel_data_bus(panel_data_bus), .frame_pulse(frame_pulse),
  .panel_power_enable(panel_power_enable),
  .refresh_active(refresh_active), .save_mode_clock_ok(save_mode_clock_ok));
`default_nettype wire

// ### bench/lcd_panel_model.sv
`timescale 1ns/1ps
`default_nettype none
// Panel side: counts frames it is shown; a halted refresh leaves it still
module lcd_panel_model (
  input wire logic frame_pulse,
  output var int   frames
);
  initial frames = 0;
  always @(posedge frame_pulse) frames++;
endmodule
`default_nettype wire

// ### bench/lcd_power_save_sequencer_test.sv
`timescale 1ns/1ps
`default_nettype none
module lcd_power_save_sequencer_test;
  import lcd_pwr_pkg::*;
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, hws;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0]  htrans;
  logic [11:0] pdat;
  logic        psh, pln, pfr, pen, ppw, ract, cok;
  int          frames, failures, check_count;
  lcd_power_save_sequencer lcd_power_save_sequencer_inst (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .hw_power_save(hws), .panel_data_bus(pdat),
    .panel_shift_clock(psh), .line_pulse(pln), .frame_pulse(pfr),
    .display_enable_out(pen), .panel_power_enable(ppw),
    .refresh_active(ract), .save_mode_clock_ok(cok));
  lcd_panel_model lcd_panel_model_inst (.frame_pulse(pfr), .frames(frames));
  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    check_count++;
    if (g !== e)
    begin
      failures++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask
  // Master holds each phase until hready is sampled high
  task automatic ahb(input logic [7:0] a, input logic w,
                     input logic [31:0] d, output logic [31:0] q);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    ahb(a, 1'b1, d, q);
  endtask
  task automatic rdc(input string n, input logic [7:0] a,
                     input logic [31:0] e);
    logic [31:0] q;
    ahb(a, 1'b0, 32'h0000_0000, q);
    chk(n, e, q);
  endtask
  task automatic t_reset();
    chk("panel", 17'h00000, {pdat, psh, pln, pfr, pen, ppw});
    rdc("save_bits", power_save_control_addr, 32'h0000_0000);
    chk("refresh", 1'b0, ract);
  endtask
  task automatic t_soft();
    int f;
    wr(mem_window_addr, 32'hA5C3_0F96);
    rdc("mem", mem_window_addr, 32'hA5C3_0F96);
    wr(lut_base_addr, 32'h0000_00FF);
    rdc("lut_save", lut_base_addr, 32'h0000_0000);
    f = frames;
    repeat (60) @(posedge hclk);
    chk("frames", f, frames);
  endtask
  task automatic t_up();
    int n;
    wr(frame_len_addr, 32'h0000_0001);
    wr(power_save_control_addr, {30'h0, ps_normal});
    n = 0;
    while (ppw !== 1'b1 && n < 2000)
    begin
      @(posedge hclk);
      n++;
    end
    chk("up_delay", 1'b1, n >= 250 && n <= 262);
    chk("clock_ok_on", 1'b0, cok);
    wr(lut_base_addr, 32'h1234_5678);
    rdc("lut_normal", lut_base_addr, 32'h1234_5678);
  endtask
  task automatic t_res();
    for (int c = 1; c < 3; c++)
    begin
      wr(power_save_control_addr, {30'h0, ps_normal});
      @(negedge hclk);
      chk("normal", 1'b1, ract);
      wr(power_save_control_addr, 32'(c));
      @(negedge hclk);
      chk("reserved", 1'b0, ract);
    end
  endtask
  task automatic t_down();
    int f;
    wr(power_save_control_addr, {30'h0, ps_soft});
    repeat (2) @(negedge hclk);
    chk("power_off", 1'b0, ppw);
    chk("panel_active", 1'b1, pen);
    wr(lut_base_addr, 32'h0000_00FF);
    rdc("lut_down", lut_base_addr, 32'h0000_0000);
    repeat (400) @(posedge hclk);
    chk("panel_low", 17'h00000, {pdat, psh, pln, pfr, pen, ppw});
    chk("clock_ok", 1'b1, cok);
    f = frames;
    repeat (40) @(posedge hclk);
    chk("frames_down", f, frames);
  endtask
  task automatic t_hard();
    wr(power_save_control_addr, {30'h0, ps_normal});
    hws <= 1'b1;
    repeat (2) @(negedge hclk);
    chk("pin_ignored", 1'b1, ract);
    wr(panel_config_addr, 32'h0000_0001);
    @(negedge hclk);
    chk("hard_mode", 1'b0, ract);
    wr(mem_window_addr, 32'h0000_0000);
    rdc("hard_read", mem_window_addr, 32'h0000_0000);
    hws <= 1'b0;
    rdc("mem_kept", mem_window_addr, 32'hA5C3_0F96);
    chk("hard_exit", 1'b1, ract);
    rdc("lut_kept", lut_base_addr, 32'h1234_5678);
  endtask
  task automatic tally_and_finish();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial
  begin
    hclk = 1'b0;
    forever #12.5 hclk = ~hclk;
  end
  // Whole run needs under a thousand cycles
  initial
  begin
    repeat (20000) @(posedge hclk);
    failures++;
    tally_and_finish();
  end
  initial
  begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0000_0000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hwdata = 32'h0000_0000;
    hws = 1'b0;
    failures = 0;
    check_count = 0;
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset();
    t_soft();
    t_up();
    t_down();
    t_res();
    t_hard();
    tally_and_finish();
  end
endmodule
`default_nettype wire
